/* File: src/hai_pkg.sv */
// package for the host attention and interrupt register block
// assumes one clock shared by the host-side and local-bus-side logic
package hai_pkg;

  // local bus addresses
  localparam logic [31:0] ADDR_RESET_CAUSE  = 32'h1ffa0014;
  localparam logic [31:0] ADDR_NMI          = 32'h1ffa001c;
  localparam logic [31:0] ADDR_COMMAND      = 32'h1ffa2000;
  localparam logic [31:0] ADDR_ATTENTION    = 32'h1ffa2004;
  localparam logic [31:0] ADDR_INT_STATUS   = 32'h1ffa200c;
  localparam logic [31:0] ADDR_BUSY_STATUS  = 32'h1ffa2010;
  localparam logic [31:0] ADDR_SOURCE_EVENT = 32'h1ffa2014;

  // command busy status fields and reset values
  localparam int          CBS_BUSY_BIT   = 0;
  localparam int          CBS_VALID_BIT  = 1;
  localparam int          CBS_REJECT_BIT = 4;
  localparam logic [7:0]  CBS_RESET      = 8'h01;

  // attention register fields
  localparam int          ATT_CODE_LSB   = 4;
  localparam logic [3:0]  ATT_CODE_MOVE  = 4'hd;

  // source event bits: low half general, high half end of transfer
  localparam int          SRC_WIDTH      = 16;
  localparam int          SRC_HALF       = 8;
  localparam logic [15:0] SRC_RESET      = 16'h0000;

  localparam logic [3:0]  NMI_INT_CODE   = 4'h0;
  localparam logic [31:0] CAUSE_RESET    = 32'h00000000;
  localparam logic [31:0] CMD_RESET_VAL  = 32'h00000000;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;

  typedef enum logic [2:0] {
    HAI_SEL_COMMAND,
    HAI_SEL_ATTENTION,
    HAI_SEL_INT_STATUS,
    HAI_SEL_BUSY_STATUS,
    HAI_SEL_NMI
  } hai_host_sel_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    hai_host_sel_t sel;
    logic [31:0]   data;
  } hai_host_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hai_lb_req_t;

  typedef struct packed {
    logic       gen;
    logic       eot;
    logic       att;
    logic       strobe;
    logic [3:0] code;
  } hai_irq_t;

endpackage : hai_pkg

/* File: src/hai_regs.sv */
// host attention, source event, reset cause and nmi registers
// assumes host writes and local bus cycles are single-cycle strobes on clk
//
// Behaviour
// - host attention write other than code d sets busy; busy holds until software reports completion or a reset-reject pulse
// - while busy or reject is set, host writes to command and attention writes other than code d are dropped
// - full reset gives status 01; command reset clears bits 4,1, sets bit 0
// - interrupt status low nibble holds the device number supplying status
// - attention code d sets the source event bit chosen by device number
// - source event bits are set only by host attention writes
// - local write clears bits written 0, ignores bits written 1
// - general interrupt is OR of source event bits 7 to 0
// - end-of-transfer interrupt is OR of source event bits 15 to 8
// - source event bits clear on full reset, command reset and rom init
// - command reset sets reset cause bit 0; full reset clears it
// - reset cause bits 31 to 1 read as zero
// - nonzero host nmi write drives interrupt code 0 and sets status bit
// - a local bus read of the nmi register clears its status bit; a host read does not
// - code d writes are not blocked by busy or reject
// - reset-reject pulse clears both busy and reject
`timescale 1ns/1ns
module hai_regs (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   cmd_reset,
  input  wire logic                   rom_init,
  input  wire logic                   reset_reject,
  input  wire hai_pkg::hai_host_req_t host,
  output logic [31:0]                 host_rdata,
  input  wire hai_pkg::hai_lb_req_t   lb,
  output logic [31:0]                 lb_rdata,
  output logic                        lb_ack,
  output hai_pkg::hai_irq_t           irq,
  output logic                        busy
);

  logic [7:0]  cbs;
  logic [7:0]  next_cbs;
  logic [31:0] command_q;
  logic [31:0] next_command_q;
  logic [7:0]  attention_q;
  logic [7:0]  next_attention_q;
  logic [7:0]  isr;
  logic [7:0]  next_isr;
  logic        cause_bit;
  logic        next_cause_bit;
  logic        att_pulse;
  logic        next_att_pulse;
  logic        int_strobe;
  logic        next_int_strobe;
  logic [31:0] next_host_rdata;
  logic [31:0] next_lb_rdata;
  logic        next_lb_ack;

  logic [15:0] src_bits;
  logic [15:0] src_set;
  logic [15:0] src_clr;
  logic        nmi_stat;
  logic        nmi_set;
  logic        nmi_clr;

  logic        blocked;
  logic        att_wr;
  logic        move_wr;
  logic        att_take;
  logic        cmd_take;
  logic [3:0]  att_code;
  logic        lb_wr_cbs;
  logic        lb_wr_src;
  logic        lb_rd_nmi;
  logic        src_clr_all;

  assign blocked   = cbs[hai_pkg::CBS_BUSY_BIT] | cbs[hai_pkg::CBS_REJECT_BIT];
  assign att_code  = host.data[hai_pkg::ATT_CODE_LSB +: 4];
  assign att_wr    = host.wr && (host.sel == hai_pkg::HAI_SEL_ATTENTION);
  assign move_wr   = att_wr && (att_code == hai_pkg::ATT_CODE_MOVE);
  assign att_take  = att_wr && !move_wr && !blocked;
  assign cmd_take  = host.wr && (host.sel == hai_pkg::HAI_SEL_COMMAND) && !blocked;
  assign lb_wr_cbs = lb.wr && (lb.addr == hai_pkg::ADDR_BUSY_STATUS);
  assign lb_wr_src = lb.wr && (lb.addr == hai_pkg::ADDR_SOURCE_EVENT);
  assign lb_rd_nmi = lb.rd && (lb.addr == hai_pkg::ADDR_NMI);
  assign src_clr_all = cmd_reset || rom_init;

  // source event bits
  always_comb
  begin
    src_set = '0;
    src_clr = '0;
    if (move_wr)
      src_set[host.data[3:0]] = 1'b1;
    if (lb_wr_src)
      src_clr = ~lb.wdata[15:0];
  end

  hai_sticky_bits #(
    .W (hai_pkg::SRC_WIDTH)
  ) u_src (
    .clk     (clk),
    .rst     (rst),
    .clr_all (src_clr_all),
    .set_vec (src_set),
    .clr_vec (src_clr),
    .bits    (src_bits)
  );

  assign nmi_set = host.wr && (host.sel == hai_pkg::HAI_SEL_NMI) && (host.data != 32'h00000000);
  assign nmi_clr = lb_rd_nmi;

  hai_sticky_bits #(
    .W (1)
  ) u_nmi (
    .clk     (clk),
    .rst     (rst),
    .clr_all (1'b0),
    .set_vec (nmi_set),
    .clr_vec (nmi_clr),
    .bits    (nmi_stat)
  );

  // host-facing registers and busy status
  always_comb
  begin
    next_cbs         = cbs;
    next_command_q   = command_q;
    next_attention_q = attention_q;
    next_isr         = isr;
    if (lb_wr_cbs)
      next_cbs = lb.wdata[7:0];                                             // completion loads the written byte; busy takes bit 0
    if (lb.wr && (lb.addr == hai_pkg::ADDR_INT_STATUS))
      next_isr = lb.wdata[7:0];
    if (reset_reject)
    begin
      next_cbs[hai_pkg::CBS_BUSY_BIT]   = 1'b0;
      next_cbs[hai_pkg::CBS_REJECT_BIT] = 1'b0;
    end
    if (cmd_take)
      next_command_q = host.data;
    if (att_take)
    begin
      next_attention_q                = host.data[7:0];
      next_cbs[hai_pkg::CBS_BUSY_BIT] = 1'b1;
    end
    if (cmd_reset)
    begin
      next_cbs                          = cbs;
      next_cbs[hai_pkg::CBS_BUSY_BIT]   = 1'b1;
      next_cbs[hai_pkg::CBS_VALID_BIT]  = 1'b0;
      next_cbs[hai_pkg::CBS_REJECT_BIT] = 1'b0;
      next_command_q                    = command_q;
      next_attention_q                  = attention_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cbs         <= hai_pkg::CBS_RESET;
      command_q   <= hai_pkg::CMD_RESET_VAL;
      attention_q <= hai_pkg::BYTE_RESET;
      isr         <= hai_pkg::BYTE_RESET;
    end
    else
    begin
      cbs         <= next_cbs;
      command_q   <= next_command_q;
      attention_q <= next_attention_q;
      isr         <= next_isr;
    end
  end

  // reset cause
  always_comb
  begin
    next_cause_bit = cause_bit;
    if (cmd_reset)
      next_cause_bit = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cause_bit <= hai_pkg::CAUSE_RESET[0];
    else
      cause_bit <= next_cause_bit;
  end

  // read data and interrupt pulses
  always_comb
  begin
    next_att_pulse  = att_take;
    next_int_strobe = nmi_set;
    next_lb_ack     = lb.rd || lb.wr;
    next_lb_rdata   = 32'h00000000;
    if (lb.rd)
    begin
      case (lb.addr)
        hai_pkg::ADDR_RESET_CAUSE:  next_lb_rdata = {31'h0, cause_bit};
        hai_pkg::ADDR_NMI:          next_lb_rdata = {31'h0, nmi_stat};
        hai_pkg::ADDR_COMMAND:      next_lb_rdata = command_q;
        hai_pkg::ADDR_ATTENTION:    next_lb_rdata = {24'h000000, attention_q};
        hai_pkg::ADDR_INT_STATUS:   next_lb_rdata = {24'h000000, isr};
        hai_pkg::ADDR_BUSY_STATUS:  next_lb_rdata = {24'h000000, cbs};
        hai_pkg::ADDR_SOURCE_EVENT: next_lb_rdata = {16'h0000, src_bits};
        default:                    next_lb_rdata = 32'h00000000;
      endcase
    end
    next_host_rdata = host_rdata;
    if (host.rd)
    begin
      case (host.sel)
        hai_pkg::HAI_SEL_COMMAND:     next_host_rdata = command_q;
        hai_pkg::HAI_SEL_ATTENTION:   next_host_rdata = {24'h000000, attention_q};
        hai_pkg::HAI_SEL_INT_STATUS:  next_host_rdata = {24'h000000, isr};
        hai_pkg::HAI_SEL_BUSY_STATUS: next_host_rdata = {24'h000000, cbs};
        hai_pkg::HAI_SEL_NMI:         next_host_rdata = {31'h0, nmi_stat};
        default:                      next_host_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      att_pulse  <= 1'b0;
      int_strobe <= 1'b0;
      lb_ack     <= 1'b0;
      lb_rdata   <= 32'h00000000;
      host_rdata <= 32'h00000000;
    end
    else
    begin
      att_pulse  <= next_att_pulse;
      int_strobe <= next_int_strobe;
      lb_ack     <= next_lb_ack;
      lb_rdata   <= next_lb_rdata;
      host_rdata <= next_host_rdata;
    end
  end

  // interrupt levels follow the held bits
  assign irq.gen    = |src_bits[hai_pkg::SRC_HALF-1:0];
  assign irq.eot    = |src_bits[hai_pkg::SRC_WIDTH-1:hai_pkg::SRC_HALF];
  assign irq.att    = att_pulse;
  assign irq.strobe = int_strobe;
  assign irq.code   = hai_pkg::NMI_INT_CODE;
  assign busy       = cbs[hai_pkg::CBS_BUSY_BIT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence quiet_s;
    !cmd_reset && !rom_init;
  endsequence

  sequence move_low_s;
    move_wr && (host.data[3] == 1'b0) && !cmd_reset && !rom_init;
  endsequence

  sequence move_high_s;
    move_wr && (host.data[3] == 1'b1) && !cmd_reset && !rom_init;
  endsequence

  sequence nmi_write_s;
    nmi_set;
  endsequence

  busy_on_att_a: assert property (att_take && !cmd_reset |=> busy [*1] ##1 1'b1 or busy)
    else $error("busy not set after accepted attention write");
  cmd_blocked_a: assert property (host.wr && host.sel == hai_pkg::HAI_SEL_COMMAND && busy |=>
    $stable(command_q))
    else $error("command register changed while busy");
  cmd_reset_status_a: assert property (cmd_reset |=>
    cbs[0] && !cbs[1] && !cbs[4] && cbs[7:5] == $past(cbs[7:5]) && cbs[3:2] == $past(cbs[3:2]))
    else $error("command reset status pattern wrong");
  move_set_a: assert property (move_wr ##0 quiet_s |=> src_bits[$past(host.data[3:0])])
    else $error("code d write did not set its source bit");
  src_origin_a: assert property ((src_bits & ~$past(src_bits)) != 16'h0000 |-> $past(move_wr))
    else $error("source bit rose without a code d write");
  src_clear_a: assert property ((lb_wr_src && !move_wr) ##0 quiet_s |=>
    src_bits == ($past(src_bits) & $past(lb.wdata[15:0])))
    else $error("source bits not cleared as written");
  gen_level_a: assert property (move_low_s |=> irq.gen [*1] ##0 irq.gen)
    else $error("general interrupt missing");
  eot_level_a: assert property (move_high_s |=> irq.eot)
    else $error("end of transfer interrupt missing");
  src_zero_a: assert property (cmd_reset || rom_init |=> src_bits == 16'h0000)
    else $error("source bits not cleared by reset");
  cause_read_a: assert property (lb.rd && lb.addr == hai_pkg::ADDR_RESET_CAUSE |=>
    lb_ack && lb_rdata == {31'h0, $past(cause_bit)})
    else $error("reset cause read wrong");
  cause_set_a: assert property (cmd_reset |=> cause_bit ##1 cause_bit)
    else $error("reset cause not set by command reset");
  isr_write_a: assert property (lb.wr && lb.addr == hai_pkg::ADDR_INT_STATUS |=>
    isr == $past(lb.wdata[7:0]))
    else $error("interrupt status not loaded by local write");
  nmi_raise_a: assert property (nmi_write_s |=> int_strobe && irq.code == 4'h0 && nmi_stat)
    else $error("nmi write did not raise code 0");
  nmi_clear_a: assert property (lb_rd_nmi && !nmi_set |=> !nmi_stat)
    else $error("nmi status not cleared by read");
  reject_clear_a: assert property (reset_reject && !att_take && !lb_wr_cbs && !cmd_reset |=>
    !busy && !cbs[4])
    else $error("reset reject left busy or reject set");

endmodule : hai_regs

/* File: src/hai_sticky_bits.sv */
// sticky flag vector: set by hardware events, cleared per bit or all at once
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ns
module hai_sticky_bits #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr_all,
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  output logic      [W-1:0] bits
);

  // refuse an empty vector while elaborating
  if (W < 1)
  begin : g_bad_width
    $error("hai_sticky_bits: W must be at least 1");
  end

  logic [W-1:0] next_bits;

  // a set arriving with a per-bit clear of the same bit wins; clr_all beats a set
  always_comb
  begin
    if (clr_all)
      next_bits = '0;
    else
      next_bits = (bits & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bits <= '0;
    else
      bits <= next_bits;
  end

endmodule : hai_sticky_bits

/* File: verification/hai_far_side.sv */
// far-side model: host bus master and resident processor issuing single-cycle strobes
// assumes one clock; every request changes on the falling edge
`timescale 1ns/1ns
module hai_far_side (
  input  wire logic              clk,
  input  wire logic [31:0]       lb_rdata,
  input  wire logic              lb_ack,
  output hai_pkg::hai_host_req_t host,
  output hai_pkg::hai_lb_req_t   lb
);
  initial
  begin
    host = '0;
    lb = '0;
  end

  // released data lines carry the inverse so a stale value never reads as live
  task automatic host_op(input logic wr, input hai_pkg::hai_host_sel_t sel, input logic [31:0] data);
    @(negedge clk);
    host.wr = wr;
    host.rd = ~wr;
    host.sel = sel;
    host.data = data;
    @(negedge clk);
    host.wr = 1'b0;
    host.rd = 1'b0;
    host.data = ~data;
  endtask : host_op

  task automatic lb_op(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = '0;
    @(negedge clk);
    lb.wr = wr;
    lb.rd = ~wr;
    lb.addr = addr;
    lb.wdata = wdata;
    @(negedge clk);
    lb.wr = 1'b0;
    lb.rd = 1'b0;
    lb.addr = ~addr;
    lb.wdata = ~wdata;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (lb_ack)
      begin
        ok = 1'b1;
        rdata = lb_rdata;
      end
      else
        @(negedge clk);
    end
  endtask : lb_op
endmodule : hai_far_side

/* File: verification/testbench.sv */
// self-checking bench for the host attention and interrupt registers
// assumes the far-side model issues strobes; sideband resets are driven here
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [3:0]  dev;
    logic [15:0] source_event_bits;
    logic        gen;
    logic        eot;
  } hai_row_t;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   cmd_reset = 1'b0;
  logic                   rom_init = 1'b0;
  logic                   reset_reject = 1'b0;
  hai_pkg::hai_host_req_t host;
  hai_pkg::hai_lb_req_t   lb;
  hai_pkg::hai_irq_t      irq;
  logic [31:0]            host_rdata;
  logic [31:0]            lb_rdata;
  logic                   lb_ack;
  logic                   busy;
  int                     errors = 0;
  int                     total_checks = 0;
  hai_row_t               rows [5] = '{'{4'h0, 16'h0001, 1'b1, 1'b0}, '{4'h7, 16'h0080, 1'b1, 1'b0},
                                      '{4'h8, 16'h0100, 1'b0, 1'b1}, '{4'ha, 16'h0400, 1'b0, 1'b1},
                                      '{4'hf, 16'h8000, 1'b0, 1'b1}};

  always #20 clk = ~clk;

  hai_regs DUT (.clk(clk), .rst(rst), .cmd_reset(cmd_reset), .rom_init(rom_init), .reset_reject(reset_reject),
                .host(host), .host_rdata(host_rdata), .lb(lb), .lb_rdata(lb_rdata), .lb_ack(lb_ack),
                .irq(irq), .busy(busy));
  hai_far_side far (.clk(clk), .lb_rdata(lb_rdata), .lb_ack(lb_ack), .host(host), .lb(lb));

  task automatic end_sim;
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic lop(input logic wr, input logic [31:0] addr, input logic [31:0] wd, input logic [31:0] exp,
                     input string name);
    logic [31:0] d;
    logic        ok;
    far.lb_op(wr, addr, wd, d, ok);
    if (!ok)
    begin
      errors++;
      end_sim();
    end
    else if (!wr)
      check(name, d, exp);
  endtask : lop

  task automatic hw(input hai_pkg::hai_host_sel_t sel, input logic [31:0] data);
    far.host_op(1'b1, sel, data);
  endtask : hw

  // host read: the registered read data stands from the edge that took the strobe
  task automatic hr(input hai_pkg::hai_host_sel_t sel, input logic [31:0] exp, input string name);
    far.host_op(1'b0, sel, 32'h0);
    check(name, host_rdata, exp);
  endtask : hr

  // one-cycle pulse: 0 command reset, 1 rom init, 2 reset reject, 3 full reset
  task automatic side(input int which);
    @(negedge clk);
    cmd_reset = (which == 0);
    rom_init = (which == 1);
    reset_reject = (which == 2);
    rst = (which == 3);
    @(negedge clk);
    {cmd_reset, rom_init, reset_reject, rst} = 4'h0;
  endtask : side

  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check("busy_rst", busy, 1'b1);
    lop(1'b0, hai_pkg::ADDR_BUSY_STATUS, 32'h0, 32'h1, "status_rst");
    lop(1'b0, hai_pkg::ADDR_RESET_CAUSE, 32'h0, 32'h0, "cause_rst");
    lop(1'b0, hai_pkg::ADDR_SOURCE_EVENT, 32'h0, 32'h0, "source_rst");
    foreach (rows[i])
    begin
      hw(hai_pkg::HAI_SEL_ATTENTION, {24'h0, hai_pkg::ATT_CODE_MOVE, rows[i].dev});
      check("gen", irq.gen, rows[i].gen);
      check("eot", irq.eot, rows[i].eot);
      check("att_d", irq.att, 1'b0);
      lop(1'b0, hai_pkg::ADDR_SOURCE_EVENT, 32'h0, {16'h0, rows[i].source_event_bits}, "source_set");
      lop(1'b1, hai_pkg::ADDR_SOURCE_EVENT, ~{16'h0, rows[i].source_event_bits}, 32'h0, "");
      check("gen_off", irq.gen | irq.eot, 1'b0);
    end
    check("busy_d", busy, 1'b1);
    lop(1'b1, hai_pkg::ADDR_BUSY_STATUS, 32'h0, 32'h0, "");
    check("busy_done", busy, 1'b0);
    hw(hai_pkg::HAI_SEL_COMMAND, 32'h12345678);
    hw(hai_pkg::HAI_SEL_ATTENTION, 32'h31);
    check("busy_set", busy, 1'b1);
    check("att", irq.att, 1'b1);
    hw(hai_pkg::HAI_SEL_COMMAND, 32'h0bad0bad);
    hw(hai_pkg::HAI_SEL_ATTENTION, 32'h05);
    check("att_drop", irq.att, 1'b0);
    lop(1'b0, hai_pkg::ADDR_COMMAND, 32'h0, 32'h12345678, "command");
    lop(1'b0, hai_pkg::ADDR_ATTENTION, 32'h0, 32'h31, "attention");
    hr(hai_pkg::HAI_SEL_COMMAND, 32'h12345678, "command_host");
    hr(hai_pkg::HAI_SEL_ATTENTION, 32'h31, "attention_host");
    hw(hai_pkg::HAI_SEL_ATTENTION, 32'hd3);
    hw(hai_pkg::HAI_SEL_ATTENTION, 32'hdc);
    lop(1'b0, hai_pkg::ADDR_SOURCE_EVENT, 32'h0, 32'h1008, "source_busy");
    lop(1'b1, hai_pkg::ADDR_SOURCE_EVENT, 32'hfffffff7, 32'h0, "");
    lop(1'b0, hai_pkg::ADDR_SOURCE_EVENT, 32'h0, 32'h1000, "source_part");
    check("eot_level", {irq.gen, irq.eot}, 2'b01);
    lop(1'b1, hai_pkg::ADDR_BUSY_STATUS, 32'h11, 32'h0, "");
    side(2);
    lop(1'b0, hai_pkg::ADDR_BUSY_STATUS, 32'h0, 32'h0, "status_rej");
    lop(1'b1, hai_pkg::ADDR_INT_STATUS, 32'ha5, 32'h0, "");
    far.host_op(1'b0, hai_pkg::HAI_SEL_INT_STATUS, 32'h0);
    @(negedge clk);
    check("int_status", host_rdata, 32'ha5);
    lop(1'b1, hai_pkg::ADDR_BUSY_STATUS, 32'hf6, 32'h0, "");
    side(0);
    lop(1'b0, hai_pkg::ADDR_BUSY_STATUS, 32'h0, 32'he5, "status_cmd");
    hr(hai_pkg::HAI_SEL_BUSY_STATUS, 32'he5, "status_host");
    lop(1'b0, hai_pkg::ADDR_SOURCE_EVENT, 32'h0, 32'h0, "source_cmd");
    lop(1'b1, hai_pkg::ADDR_RESET_CAUSE, 32'hfffffffe, 32'h0, "");
    lop(1'b0, hai_pkg::ADDR_RESET_CAUSE, 32'h0, 32'h1, "cause_cmd");
    side(3);
    lop(1'b0, hai_pkg::ADDR_RESET_CAUSE, 32'h0, 32'h0, "cause_full");
    hw(hai_pkg::HAI_SEL_ATTENTION, 32'hd1);
    side(1);
    lop(1'b0, hai_pkg::ADDR_SOURCE_EVENT, 32'h0, 32'h0, "source_rom");
    lop(1'b0, 32'h1ffa0030, 32'h0, 32'h0, "unmapped");
    hw(hai_pkg::HAI_SEL_NMI, 32'h80);
    check("nmi_int", {irq.strobe, irq.code}, {1'b1, hai_pkg::NMI_INT_CODE});
    hr(hai_pkg::HAI_SEL_NMI, 32'h1, "nmi_host");
    lop(1'b0, hai_pkg::ADDR_NMI, 32'h0, 32'h1, "nmi_set");
    lop(1'b0, hai_pkg::ADDR_NMI, 32'h0, 32'h0, "nmi_clr");
    hw(hai_pkg::HAI_SEL_NMI, 32'h0);
    check("nmi_zero", irq.strobe, 1'b0);
    lop(1'b0, hai_pkg::ADDR_NMI, 32'h0, 32'h0, "nmi_none");
    end_sim();
  end
endmodule : testbench
